// >>> design/io_window_decode.sv
/*
 * i/o window decoder: tells whether an i/o address falls inside the
 * forwarded range given by the base and top nibbles.
 * assumes requests come from logic on the same clock.
 */
`timescale 1ns/1ps
module io_window_decode
    import sec_status_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // window and request
    io_window_if.dec win
);
    logic hit_valid_ff;
    logic hit_ff;
    logic nxt_hit;

    // inclusive bound check
    // low twelve bits span 000..fff, so the nibble compare is exact
    always_comb begin
        nxt_hit = (win.req_addr[31:16] == UPPER_ADDR_ZERO) &&
                  (win.req_addr[TOP_MSB:TOP_LSB] >= win.window_base) &&
                  (win.req_addr[TOP_MSB:TOP_LSB] <= win.window_top);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hit_valid_ff <= 1'b0;
            hit_ff <= 1'b0;
        end else begin
            hit_valid_ff <= win.req_valid;
            hit_ff <= win.req_valid & nxt_hit;
        end
    end

    assign win.hit_valid = hit_valid_ff;
    assign win.hit = hit_ff;
endmodule : io_window_decode

// >>> design/sec_status_io_window.sv
/*
 * secondary status and i/o window register with apb slave, sticky
 * interrupt status, and i/o forward decode.
 * assumes event inputs are one-cycle pulses from logic on clk, and the
 * system error line is an asynchronous active-low pin.
 */
// Overview of operation
// - parity errors set bit 31, write-one clears
// - system error line sets bit 30, w1c
// - master-abort as master sets bit 29, w1c
// - target-abort received as master sets 28, w1c
// - target-abort signaled as target sets 27
// - bits 26:25 read-only medium devsel 01
// - uncorrectable data error sets bit 24, w1c
// - bit 23 hardwired one, back-to-back capable
// - bit 21 hardwired one, 66 MHz capable
// - bits 15:12 give window top, low fff
// - bits 7:4 give window base, low 000
// - capability nibbles read-only, value 0x1
`timescale 1ns/1ps
module sec_status_io_window
    import sec_status_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // secondary bus events
    input wire logic parity_error_event,
    input wire logic system_error_line_n,
    input wire logic master_abort_event,
    input wire logic target_abort_rx_event,
    input wire logic target_abort_tx_event,
    input wire logic data_error_event,
    // i/o forward decode
    input wire logic io_req_valid,
    input wire logic [31:0] io_req_addr,
    output logic io_fwd_valid,
    output logic io_fwd_hit,
    // interrupt
    output logic irq
);
    // apb state
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;
    logic wr_fire;

    // register contents
    logic [NUM_EVENTS-1:0] flag_ff;
    logic [NUM_EVENTS-1:0] irq_status_ff;
    logic [NUM_EVENTS-1:0] irq_enable_ff;
    logic [3:0] io_window_top_ff;
    logic [3:0] io_window_base_ff;
    logic irq_ff;

    // pin synchroniser
    logic serr_meta_ff;
    logic serr_sync_ff;

    // decode helpers
    logic [NUM_EVENTS-1:0] events;
    logic [NUM_EVENTS-1:0] flag_clr;
    logic [NUM_EVENTS-1:0] irq_clr;
    logic [31:0] window_word;
    logic sel_window;
    logic sel_status;
    logic sel_clear;
    logic sel_enable;
    logic fwd_valid_ff;
    logic fwd_hit_ff;

    io_window_if win ();

    // system error pin is asynchronous, two flops before use
    // reset to idle level so no false event follows reset
    always_ff @(posedge clk) begin
        if (rst) begin
            serr_meta_ff <= 1'b1;
            serr_sync_ff <= 1'b1;
        end else begin
            serr_meta_ff <= system_error_line_n;
            serr_sync_ff <= serr_meta_ff;
        end
    end

    // event vector in status order
    always_comb begin
        events = '0;
        events[EV_PARITY] = parity_error_event;
        events[EV_SYSTEM_ERROR] = ~serr_sync_ff;
        events[EV_MASTER_ABORT] = master_abort_event;
        events[EV_TARGET_ABORT_RX] = target_abort_rx_event;
        events[EV_TARGET_ABORT_TX] = target_abort_tx_event;
        events[EV_DATA_ERROR] = data_error_event;
    end

    // address decode
    always_comb begin
        sel_window = 1'b0;
        sel_status = 1'b0;
        sel_clear = 1'b0;
        sel_enable = 1'b0;
        if (paddr == OFF_STATUS_IO_WINDOW) begin
            sel_window = 1'b1;
        end else if (paddr == OFF_IRQ_STATUS) begin
            sel_status = 1'b1;
        end else if (paddr == OFF_IRQ_CLEAR) begin
            sel_clear = 1'b1;
        end else if (paddr == OFF_IRQ_ENABLE) begin
            sel_enable = 1'b1;
        end
    end

    // write commits only at the edge that completes the access
    // refused accesses select no writable register, so they change nothing
    assign wr_fire = psel & penable & pready_ff & pwrite;

    // write-one-clear masks, per bit
    generate
        for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_clr
            assign flag_clr[i] = wr_fire & sel_window & pwdata[EVENT_POS[i]];
            assign irq_clr[i] = wr_fire & sel_clear & pwdata[i];
        end
    endgenerate

    // sticky flags; a set in the clear cycle wins
    generate
        for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_flag
            always_ff @(posedge clk) begin
                if (rst) begin
                    flag_ff[i] <= 1'b0;
                end else begin
                    flag_ff[i] <= events[i] | (flag_ff[i] & ~flag_clr[i]);
                end
            end
            // separate copy, so clearing one view keeps the other
            always_ff @(posedge clk) begin
                if (rst) begin
                    irq_status_ff[i] <= 1'b0;
                end else begin
                    irq_status_ff[i] <= events[i] | (irq_status_ff[i] & ~irq_clr[i]);
                end
            end
        end
    endgenerate

    // writable window fields
    always_ff @(posedge clk) begin
        if (rst) begin
            io_window_top_ff <= RST_STATUS_IO_WINDOW[TOP_MSB:TOP_LSB];
            io_window_base_ff <= RST_STATUS_IO_WINDOW[BASE_MSB:BASE_LSB];
        end else begin
            if (wr_fire && sel_window) begin
                io_window_top_ff <= pwdata[TOP_MSB:TOP_LSB];
                io_window_base_ff <= pwdata[BASE_MSB:BASE_LSB];
            end
        end
    end

    // interrupt enables; bits above the event count do not exist
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_enable_ff <= '0;
        end else begin
            if (wr_fire && sel_enable) begin
                irq_enable_ff <= pwdata[NUM_EVENTS-1:0];
            end
        end
    end

    // assemble the window register for reads
    always_comb begin
        window_word = DATA_ZERO;
        // reserved bits keep the zero default
        for (int i = 0; i < NUM_EVENTS; i++) begin
            window_word[EVENT_POS[i]] = flag_ff[i];
        end
        window_word[DEVSEL_MSB:DEVSEL_LSB] = DEVSEL_MEDIUM;
        window_word[BIT_BACK_TO_BACK_CAPABLE] = HARDWIRED_ONE;
        window_word[BIT_HIGH_SPEED_CAPABLE] = HARDWIRED_ONE;
        window_word[TOP_MSB:TOP_LSB] = io_window_top_ff;
        window_word[CAP_UPPER_MSB:CAP_UPPER_LSB] = IO_WIDTH_CAP_32;
        window_word[BASE_MSB:BASE_LSB] = io_window_base_ff;
        window_word[CAP_LOWER_MSB:CAP_LOWER_LSB] = IO_WIDTH_CAP_32;
    end

    // read mux; reserved and write-only read zero
    always_comb begin
        nxt_prdata = DATA_ZERO;
        nxt_pslverr = 1'b0;
        if (sel_window) begin
            nxt_prdata = window_word;
        end else if (sel_status) begin
            // read-only: a write is refused and dropped
            nxt_prdata[NUM_EVENTS-1:0] = irq_status_ff;
            nxt_pslverr = pwrite;
        end else if (sel_clear) begin
            nxt_prdata = DATA_ZERO;
        end else if (sel_enable) begin
            nxt_prdata[NUM_EVENTS-1:0] = irq_enable_ff;
        end else begin
            nxt_pslverr = 1'b1;
        end
    end

    // answer prepared in setup, ready in the first access cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= psel & ~penable;
        end
    end

    // read data stands only with ready, zero otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_ff <= DATA_ZERO;
        end else begin
            if (psel && !penable && !pwrite) begin
                prdata_ff <= nxt_prdata;
            end else begin
                prdata_ff <= DATA_ZERO;
            end
        end
    end

    // error flag stands only with ready
    always_ff @(posedge clk) begin
        if (rst) begin
            pslverr_ff <= 1'b0;
        end else begin
            if (psel && !penable) begin
                pslverr_ff <= nxt_pslverr;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // level interrupt from enabled sticky bits
    // registered, so decode settling never shows on the pin
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_status_ff & irq_enable_ff);
        end
    end

    // window values and requests to the decoder
    assign win.window_base = io_window_base_ff;
    assign win.window_top = io_window_top_ff;
    assign win.req_valid = io_req_valid;
    assign win.req_addr = io_req_addr;

    io_window_decode u_decode (
        .clk(clk),
        .rst(rst),
        .win(win.dec)
    );

    // decoder result already registered; one more flop keeps outputs local
    always_ff @(posedge clk) begin
        if (rst) begin
            fwd_valid_ff <= 1'b0;
        end else begin
            fwd_valid_ff <= win.hit_valid;
        end
    end

    // hit only ever rises together with its valid
    always_ff @(posedge clk) begin
        if (rst) begin
            fwd_hit_ff <= 1'b0;
        end else begin
            fwd_hit_ff <= win.hit;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign io_fwd_valid = fwd_valid_ff;
    assign io_fwd_hit = fwd_hit_ff;
endmodule : sec_status_io_window

// >>> inc/io_window_if.sv
/*
 * carrier between the register block and the i/o window decoder.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface io_window_if;
    logic [3:0] window_base;
    logic [3:0] window_top;
    logic req_valid;
    logic [31:0] req_addr;
    logic hit_valid;
    logic hit;

    modport regs (
        output window_base,
        output window_top,
        output req_valid,
        output req_addr,
        input hit_valid,
        input hit
    );

    modport dec (
        input window_base,
        input window_top,
        input req_valid,
        input req_addr,
        output hit_valid,
        output hit
    );
endinterface : io_window_if

// >>> inc/sec_status_pkg.sv
/*
 * constants for the secondary status and i/o window register block:
 * register offsets, field positions, reset values and event bit order.
 * assumes a 32-bit apb register bus and byte addressing.
 */
package sec_status_pkg;

    // register byte offsets
    localparam logic [11:0] OFF_STATUS_IO_WINDOW = 12'h01c;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h040;
    localparam logic [11:0] OFF_IRQ_CLEAR = 12'h044;
    localparam logic [11:0] OFF_IRQ_ENABLE = 12'h048;
    localparam logic [31:0] RST_STATUS_IO_WINDOW = 32'h02a00101;
    localparam logic [31:0] DATA_ZERO = 32'h00000000;

    // status flag and field positions in the window register
    localparam int BIT_PARITY_ERROR_SEEN = 31;
    localparam int BIT_SYSTEM_ERROR_RECEIVED = 30;
    localparam int BIT_MASTER_ABORT_RECEIVED = 29;
    localparam int BIT_TARGET_ABORT_RECEIVED = 28;
    localparam int BIT_TARGET_ABORT_SIGNALED = 27;
    localparam int BIT_UNCORRECTABLE_DATA_ERROR = 24;
    localparam int BIT_BACK_TO_BACK_CAPABLE = 23;
    localparam int BIT_HIGH_SPEED_CAPABLE = 21;
    localparam int DEVSEL_MSB = 26;
    localparam int DEVSEL_LSB = 25;
    localparam int TOP_MSB = 15;
    localparam int TOP_LSB = 12;
    localparam int CAP_UPPER_MSB = 11;
    localparam int CAP_UPPER_LSB = 8;
    localparam int BASE_MSB = 7;
    localparam int BASE_LSB = 4;
    localparam int CAP_LOWER_MSB = 3;
    localparam int CAP_LOWER_LSB = 0;

    // read-only field values
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam logic HARDWIRED_ONE = 1'b1;
    localparam logic [3:0] IO_WIDTH_CAP_32 = 4'h1;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;
    localparam logic [15:0] UPPER_ADDR_ZERO = 16'h0000;

    // event order; index is also the interrupt status bit
    localparam int NUM_EVENTS = 6;
    localparam int EV_PARITY = 0;
    localparam int EV_SYSTEM_ERROR = 1;
    localparam int EV_MASTER_ABORT = 2;
    localparam int EV_TARGET_ABORT_RX = 3;
    localparam int EV_TARGET_ABORT_TX = 4;
    localparam int EV_DATA_ERROR = 5;
    localparam int EVENT_POS [NUM_EVENTS] = '{
        BIT_PARITY_ERROR_SEEN, BIT_SYSTEM_ERROR_RECEIVED, BIT_MASTER_ABORT_RECEIVED,
        BIT_TARGET_ABORT_RECEIVED, BIT_TARGET_ABORT_SIGNALED, BIT_UNCORRECTABLE_DATA_ERROR
    };

endpackage : sec_status_pkg

// >>> testbench/bridge_secondary_status_io_window_tb_top.sv
/* self-checking bench for the status and window register over apb.
   assumes the bus agent model drives every secondary bus input. */
`timescale 1ns/1ps
module bridge_secondary_status_io_window_tb_top
    import sec_status_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, io_req_addr, rd, ev_bit;
    logic pready, pslverr, io_fwd_valid, io_fwd_hit, irq, er, io_req_valid;
    logic parity_error_event, system_error_line_n, master_abort_event;
    logic target_abort_rx_event, target_abort_tx_event, data_error_event;
    logic [31:0] ioa [5] = '{32'h00001fff, 32'h00002000, 32'h00003fff, 32'h00004000, 32'h00012000};
    logic ioh [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    localparam logic [31:0] WIN = RST_STATUS_IO_WINDOW | 32'h00003020;
    int bad_count = 0;
    int checks_done = 0;

    sec_status_io_window sec_status_io_window_inst (.clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .parity_error_event, .system_error_line_n,
        .master_abort_event, .target_abort_rx_event, .target_abort_tx_event, .data_error_event,
        .io_req_valid, .io_req_addr, .io_fwd_valid, .io_fwd_hit, .irq);
    sec_bus_agent sec_bus_agent_inst (.clk, .parity_error_event, .system_error_line_n,
        .master_abort_event, .target_abort_rx_event, .target_abort_tx_event, .data_error_event,
        .io_req_valid, .io_req_addr);

    initial begin
        forever #10 clk = ~clk;
    end

    task chk32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk32

    task chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask : chk1

    // holds the request until ready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no wait count assumed; only the watchdog ends a hung access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h00000000);
        chk32(rd, exp);
        chk1(er, e);
    endtask : rchk

    task wchk(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        chk1(er, e);
    endtask : wchk

    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        complete_run;
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rchk(OFF_STATUS_IO_WINDOW, RST_STATUS_IO_WINDOW, 1'b0);
        rchk(OFF_IRQ_ENABLE, DATA_ZERO, 1'b0);
        $display("test reset done");
        wchk(OFF_STATUS_IO_WINDOW, 32'hffffffff, 1'b0);
        rchk(OFF_STATUS_IO_WINDOW, 32'h02a0f1f1, 1'b0);
        wchk(OFF_STATUS_IO_WINDOW, 32'h00003020, 1'b0);
        rchk(OFF_STATUS_IO_WINDOW, WIN, 1'b0);
        $display("test fields done");
        for (int i = 0; i < 5; i++) begin
            sec_bus_agent_inst.io_ask(ioa[i]);
            @(posedge clk);
            #1;
            chk1(io_fwd_valid, 1'b1);
            chk1(io_fwd_hit, ioh[i]);
        end
        $display("test decode done");
        wchk(OFF_IRQ_ENABLE, 32'h0000003f, 1'b0);
        for (int i = 0; i < NUM_EVENTS; i++) begin
            ev_bit = 32'h1 << EVENT_POS[i];
            sec_bus_agent_inst.fire(i);
            repeat (5) @(posedge clk);
            #1;
            chk1(irq, 1'b1);
            rchk(OFF_STATUS_IO_WINDOW, WIN | ev_bit, 1'b0);
            rchk(OFF_IRQ_STATUS, 32'h1 << i, 1'b0);
            wchk(OFF_STATUS_IO_WINDOW, 32'h00003020 | ev_bit, 1'b0);
            wchk(OFF_IRQ_CLEAR, 32'h1 << i, 1'b0);
            rchk(OFF_STATUS_IO_WINDOW, WIN, 1'b0);
            rchk(OFF_IRQ_STATUS, DATA_ZERO, 1'b0);
            chk1(irq, 1'b0);
        end
        wchk(OFF_IRQ_ENABLE, DATA_ZERO, 1'b0);
        sec_bus_agent_inst.fire(EV_MASTER_ABORT);
        repeat (5) @(posedge clk);
        #1;
        chk1(irq, 1'b0);
        rchk(OFF_IRQ_STATUS, 32'h1 << EV_MASTER_ABORT, 1'b0);
        rchk(OFF_STATUS_IO_WINDOW, WIN | 32'h20000000, 1'b0);
        $display("test events done");
        rchk(12'h100, DATA_ZERO, 1'b1);
        wchk(OFF_IRQ_STATUS, 32'h0000003f, 1'b1);
        rchk(OFF_IRQ_CLEAR, DATA_ZERO, 1'b0);
        rchk(OFF_IRQ_STATUS, 32'h1 << EV_MASTER_ABORT, 1'b0);
        $display("test refusals done");
        // mid-run reset must drop the pending flag and the window fields
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rchk(OFF_STATUS_IO_WINDOW, RST_STATUS_IO_WINDOW, 1'b0);
        rchk(OFF_IRQ_STATUS, DATA_ZERO, 1'b0);
        chk1(irq, 1'b0);
        $display("test second reset done");
        complete_run;
    end
endmodule : bridge_secondary_status_io_window_tb_top

// >>> testbench/sec_bus_agent.sv
/* secondary bus agents: status events, error pin and forward requests.
   assumes the register block clock. */
`timescale 1ns/1ps
module sec_bus_agent
    import sec_status_pkg::*;
(
    // clock
    input wire logic clk,
    // status events
    output logic parity_error_event,
    output logic system_error_line_n,
    output logic master_abort_event,
    output logic target_abort_rx_event,
    output logic target_abort_tx_event,
    output logic data_error_event,
    // forward requests
    output logic io_req_valid,
    output logic [31:0] io_req_addr
);
    logic [5:0] pulse_ff = 6'h00;
    initial begin
        io_req_valid = 1'b0;
        io_req_addr = 32'h00000000;
    end
    assign parity_error_event = pulse_ff[EV_PARITY];
    // pin idles high, driven low only while its pulse bit is set
    assign system_error_line_n = ~pulse_ff[EV_SYSTEM_ERROR];
    assign master_abort_event = pulse_ff[EV_MASTER_ABORT];
    assign target_abort_rx_event = pulse_ff[EV_TARGET_ABORT_RX];
    assign target_abort_tx_event = pulse_ff[EV_TARGET_ABORT_TX];
    assign data_error_event = pulse_ff[EV_DATA_ERROR];

    task fire(input int i);
        @(posedge clk);
        pulse_ff <= 6'h01 << i;
        @(posedge clk);
        pulse_ff <= 6'h00;
    endtask : fire

    task io_ask(input logic [31:0] a);
        @(posedge clk);
        io_req_valid <= 1'b1;
        io_req_addr <= a;
        @(posedge clk);
        io_req_valid <= 1'b0;
        // released address inverted, so a stale value never looks valid
        io_req_addr <= ~a;
    endtask : io_ask
endmodule : sec_bus_agent

// >>> testbench/sec_status_io_window_properties.sv
/* port assertions for the status and window register.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module sec_status_io_window_chk
    import sec_status_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // decode
    input wire logic io_req_valid,
    input wire logic [31:0] io_req_addr,
    input wire logic io_fwd_valid,
    input wire logic io_fwd_hit
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire rd_win = psel && penable && pready && !pwrite && paddr == OFF_STATUS_IO_WINDOW;
    wire mapped = paddr inside {OFF_STATUS_IO_WINDOW, OFF_IRQ_STATUS, OFF_IRQ_CLEAR,
        OFF_IRQ_ENABLE};

    AST_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_QUIET: assert property (!pready |-> prdata == DATA_ZERO)
        else $error("read data outside answer");
    AST_UNMAPPED: assert property (psel && !penable && !mapped |=>
        pslverr && prdata == DATA_ZERO)
        else $error("unmapped access not refused");
    AST_DEVSEL: assert property (rd_win |-> prdata[26:25] == DEVSEL_MEDIUM)
        else $error("select timing field wrong");
    AST_B2B: assert property (rd_win |-> prdata[23])
        else $error("back to back bit low");
    AST_SPEED: assert property (rd_win |-> prdata[21])
        else $error("speed bit low");
    AST_CAP: assert property (rd_win |-> prdata[11:8] == IO_WIDTH_CAP_32 &&
        prdata[3:0] == IO_WIDTH_CAP_32)
        else $error("width capability wrong");
    AST_RSVD: assert property (rd_win |-> !prdata[22] && prdata[20:16] == 5'h00)
        else $error("reserved bits not zero");
    AST_FWD: assert property (io_req_valid |-> ##2 io_fwd_valid)
        else $error("no decode answer");
    AST_UPPER: assert property (io_req_valid && io_req_addr[31:16] != 16'h0000 |->
        ##2 !io_fwd_hit)
        else $error("upper address hit");
    AST_HITVALID: assert property (io_fwd_hit |-> io_fwd_valid)
        else $error("hit without valid");
endmodule : sec_status_io_window_chk

bind sec_status_io_window sec_status_io_window_chk sec_status_io_window_chk_inst (.clk, .rst,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .io_req_valid,
    .io_req_addr, .io_fwd_valid, .io_fwd_hit);
